/* rtl/csw_pkg.sv */
package csw_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] CSW_LOWER_OFS = 8'h00;
   localparam logic [7:0] CSW_UPPER_OFS = 8'h04;
   localparam logic [7:0] CSW_MIDMEM_OFS = 8'h08;
   localparam logic [7:0] CSW_MIDPER_OFS = 8'h0c;
   localparam logic [7:0] CSW_PERCTL_OFS = 8'h10;
   localparam logic [7:0] CSW_STATUS_OFS = 8'h14;
   // common ready / wait field
   localparam int CSW_RDIS_BIT = 2;
   localparam int CSW_WAIT_LSB = 0;
   localparam int CSW_WAIT_W = 2;
   // lower / upper config: block size code, 1 KB shifted by code
   localparam int CSW_SIZE_LSB = 3;
   localparam int CSW_SIZE_W = 4;
   localparam logic [3:0] CSW_SIZE_MAX = 4'h8;
   // mid memory config: start address bits 19:13
   localparam int CSW_MSTART_LSB = 9;
   localparam int CSW_MSTART_W = 7;
   // mid / peripheral config: block size, pin selector, space select
   localparam int CSW_MSIZE_LSB = 8;
   localparam int CSW_MSIZE_W = 7;
   localparam int CSW_EX_BIT = 7;
   localparam int CSW_SPACE_BIT = 6;
   // peripheral control: start address bits 19:10
   localparam int CSW_PSTART_LSB = 6;
   localparam int CSW_PSTART_W = 10;
   // address map figures
   localparam logic [19:0] CSW_KB = 20'h00400;
   localparam logic [19:0] CSW_MID_UNIT = 20'h02000;
   localparam logic [19:0] CSW_PER_SPAN = 20'h00380;
   localparam int CSW_PER_WIN_SHIFT = 7;
   localparam int CSW_NUM_PER = 7;
   localparam int CSW_NUM_MID = 4;
   // register reset values (every field resets to zero)
   localparam logic [15:0] CSW_REG_RST = 16'h0000;
   typedef enum logic [1:0] {CSW_IDLE, CSW_ACTIVE} csw_state_t;
endpackage

/* rtl/csw_top.sv */
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: peripheral selects hit when address is at or above programmed start.
// RULE2: software keeps start bits 19:16 zero for I/O use.
// RULE3: ready-disable clear needs ready to end; set ends after wait count.
// RULE4: wait count is the minimum waits; zero means none unless ready decides.
// RULE5: software writes zero to reserved bits of peripheral control.
// RULE6: any access of peripheral control plus mid/peripheral config enables selects.
// RULE7: software programs mid/peripheral, then mid memory, then peripheral control.
// RULE8: lower memory select always starts at address zero.
// RULE9: upper memory select starts at one megabyte minus block size.
// RULE10: software aligns the mid base to the mid block size.
// RULE11: largest mid block with top start bit set overlaps upper select.
// RULE12: seven peripheral selects, each a 128-byte window above the base.
// RULE13: peripheral base sits on any 1 KB boundary.
// RULE14: upper memory select ends at the top byte of memory.
// RULE15: lower memory select ends one byte below its block size.
// RULE16: lower and upper block sizes run 1 KB through 256 KB.
// RULE17: each mid select covers one consecutive quarter of the mid block.
// RULE18: zero to three automatic wait states per cycle from the select.
// RULE19: ready never shortens automatic waits; ignored ready never lengthens.
// RULE20: external device holds ready inactive to add waits.
// RULE21: software keeps ready enabled for slow devices.
// RULE22: any mid select active means mid/peripheral wait and ready settings.
// RULE23: during hold acknowledge every select stays inactive.
// RULE24: an enabled select can never be disabled again.
// RULE25: space select bit picks I/O (clear) or memory (set) for peripherals.
// RULE26: selects are active low and held for the whole cycle.
// RULE27: waits count whole clocks; ready sampled only after they expire.
module csw_top (
   input wire logic clock_in,
   input wire logic nrst_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // internal bus cycle from the processor
   input wire logic cycle_start_in,
   input wire logic [19:0] cycle_addr_in,
   input wire logic cycle_mem_in,
   input wire logic cycle_io_in,
   input wire logic bus_ready_in,
   input wire logic hold_acknowledge_in,
   output logic cycle_done_out,
   // chip selects, active low
   output logic lower_memory_select_n_out,
   output logic upper_memory_select_n_out,
   output logic [csw_pkg::CSW_NUM_MID-1:0] mid_range_select_n_out,
   output logic [csw_pkg::CSW_NUM_PER-1:0] peripheral_select_n_out
);
   import csw_pkg::*;

   // index of highest set bit of mid block size field
   function automatic logic [2:0] msb_index(input logic [6:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // reset release through two flops
   logic rst_meta_r;
   logic rst_sync_r;
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   wire logic rst_n = rst_sync_r;

   // configuration registers and enables
   logic [15:0] lower_memory_config_reg_r;
   logic [15:0] upper_memory_config_reg_r;
   logic [15:0] mid_memory_config_reg_r;
   logic [15:0] mid_peripheral_config_reg_r;
   logic [15:0] peripheral_select_control_r;
   logic acc_lower_r, acc_upper_r, acc_midmem_r, acc_midper_r, acc_perctl_r;

   // bus slave data phase state
   logic dphase_r;
   logic dwrite_r;
   logic [7:0] daddr_r;
   logic [31:0] hrdata_r;
   logic hreadyout_r;

   wire logic addr_take = hsel_in & htrans_in[1] & hready_in;
   wire logic hit_lower_reg = (daddr_r == CSW_LOWER_OFS);
   wire logic hit_upper_reg = (daddr_r == CSW_UPPER_OFS);
   wire logic hit_midmem_reg = (daddr_r == CSW_MIDMEM_OFS);
   wire logic hit_midper_reg = (daddr_r == CSW_MIDPER_OFS);
   wire logic hit_perctl_reg = (daddr_r == CSW_PERCTL_OFS);
   wire logic hit_status_reg = (daddr_r == CSW_STATUS_OFS);
   wire logic wr_now = dphase_r & dwrite_r;
   wire logic [15:0] wd = hwdata_in[15:0];

   // write masks keep reserved bits at zero
   localparam logic [15:0] LU_MASK = 16'h007f;
   localparam logic [15:0] MM_MASK = 16'hfe07;
   localparam logic [15:0] MP_MASK = 16'h7fc7;
   localparam logic [15:0] PC_MASK = 16'hffc7;

   // enables: sticky, only reset clears them
   wire logic en_lower = acc_lower_r;
   wire logic en_upper = acc_upper_r;
   wire logic en_mid = acc_midmem_r & acc_midper_r;
   wire logic en_per = acc_perctl_r & acc_midper_r; // RULE6

   csw_state_t state_r;
   logic [csw_pkg::CSW_WAIT_W-1:0] wcnt_r;

   // read data selection
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_lower_reg) begin
         rd_val = {16'h0000, lower_memory_config_reg_r};
      end else if (hit_upper_reg) begin
         rd_val = {16'h0000, upper_memory_config_reg_r};
      end else if (hit_midmem_reg) begin
         rd_val = {16'h0000, mid_memory_config_reg_r};
      end else if (hit_midper_reg) begin
         rd_val = {16'h0000, mid_peripheral_config_reg_r};
      end else if (hit_perctl_reg) begin
         rd_val = {16'h0000, peripheral_select_control_r};
      end else if (hit_status_reg) begin
         rd_val = {26'h0, hold_acknowledge_in, state_r == CSW_ACTIVE,
                   en_per, en_mid, en_upper, en_lower};
      end
   end

   // address phase capture, one wait state, then answer
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         dphase_r <= 1'b0;
         dwrite_r <= 1'b0;
         daddr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
      end else if (dphase_r) begin
         dphase_r <= 1'b0;
         hrdata_r <= rd_val;
         hreadyout_r <= 1'b1;
      end else if (addr_take) begin
         dphase_r <= 1'b1;
         dwrite_r <= hwrite_in;
         daddr_r <= haddr_in[7:0];
         hreadyout_r <= 1'b0;
      end
   end

   // register writes and access tracking
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         lower_memory_config_reg_r <= CSW_REG_RST;
         upper_memory_config_reg_r <= CSW_REG_RST;
         mid_memory_config_reg_r <= CSW_REG_RST;
         mid_peripheral_config_reg_r <= CSW_REG_RST;
         peripheral_select_control_r <= CSW_REG_RST;
         acc_lower_r <= 1'b0;
         acc_upper_r <= 1'b0;
         acc_midmem_r <= 1'b0;
         acc_midper_r <= 1'b0;
         acc_perctl_r <= 1'b0;
      end else if (dphase_r) begin
         // any read or write enables, nothing disables
         acc_lower_r <= acc_lower_r | hit_lower_reg; // RULE24
         acc_upper_r <= acc_upper_r | hit_upper_reg;
         acc_midmem_r <= acc_midmem_r | hit_midmem_reg;
         acc_midper_r <= acc_midper_r | hit_midper_reg; // RULE6
         acc_perctl_r <= acc_perctl_r | hit_perctl_reg;
         if (wr_now && hit_lower_reg) begin
            lower_memory_config_reg_r <= wd & LU_MASK;
         end
         if (wr_now && hit_upper_reg) begin
            upper_memory_config_reg_r <= wd & LU_MASK;
         end
         if (wr_now && hit_midmem_reg) begin
            mid_memory_config_reg_r <= wd & MM_MASK;
         end
         if (wr_now && hit_midper_reg) begin
            mid_peripheral_config_reg_r <= wd & MP_MASK;
         end
         if (wr_now && hit_perctl_reg) begin
            peripheral_select_control_r <= wd & PC_MASK;
         end
      end
   end

   // field extraction
   wire logic [3:0] lsz_raw = lower_memory_config_reg_r[CSW_SIZE_LSB +: CSW_SIZE_W];
   wire logic [3:0] usz_raw = upper_memory_config_reg_r[CSW_SIZE_LSB +: CSW_SIZE_W];
   wire logic [3:0] lsz = (lsz_raw > CSW_SIZE_MAX) ? CSW_SIZE_MAX : lsz_raw; // RULE16
   wire logic [3:0] usz = (usz_raw > CSW_SIZE_MAX) ? CSW_SIZE_MAX : usz_raw;
   wire logic [19:0] lower_size = CSW_KB << lsz;
   wire logic [19:0] upper_size = CSW_KB << usz;
   wire logic [2:0] mid_idx =
      msb_index(mid_peripheral_config_reg_r[CSW_MSIZE_LSB +: CSW_MSIZE_W]);
   wire logic [19:0] mid_size = CSW_MID_UNIT << mid_idx;
   wire logic [19:0] mid_base =
      {mid_memory_config_reg_r[CSW_MSTART_LSB +: CSW_MSTART_W], 13'h0000};
   wire logic [19:0] per_base =
      {peripheral_select_control_r[CSW_PSTART_LSB +: CSW_PSTART_W], 10'h000}; // RULE13
   wire logic pin_ex = mid_peripheral_config_reg_r[CSW_EX_BIT];
   wire logic per_mem = mid_peripheral_config_reg_r[CSW_SPACE_BIT];

   // address decode of the offered cycle
   wire logic [19:0] a = cycle_addr_in;
   wire logic [19:0] mid_off = a - mid_base;
   wire logic [19:0] per_off = a - per_base;
   wire logic [19:0] upper_start = 20'h00000 - upper_size; // RULE9
   wire logic per_space = per_mem ? cycle_mem_in : cycle_io_in; // RULE25
   // lower: zero through size minus one
   wire logic hit_lower = en_lower & cycle_mem_in & (a < lower_size); // RULE8 RULE15
   // upper: runs to the last byte of the 1 MB space
   wire logic hit_upper = en_upper & cycle_mem_in & (a >= upper_start); // RULE14
   // mid: no upper bound clip, so top block may overlap upper
   wire logic hit_mid = en_mid & cycle_mem_in & (a >= mid_base)
                        & (mid_off < mid_size); // RULE11
   wire logic [19:0] mid_q = mid_off >> (5'h0b + {2'b00, mid_idx});
   wire logic [1:0] mid_sel = mid_q[1:0]; // RULE17
   wire logic hit_per = en_per & per_space & (a >= per_base)
                        & (per_off < CSW_PER_SPAN); // RULE1
   wire logic [2:0] per_sel = per_off[CSW_PER_WIN_SHIFT +: 3]; // RULE12

   // one-hot select vectors
   logic [CSW_NUM_MID-1:0] mid_vec;
   logic [CSW_NUM_PER-1:0] per_vec;
   genvar gi;
   generate
      for (gi = 0; gi < CSW_NUM_MID; gi++) begin : g_mid
         assign mid_vec[gi] = hit_mid & (mid_sel == 2'(gi));
      end
      for (gi = 0; gi < CSW_NUM_PER; gi++) begin : g_per
         assign per_vec[gi] = hit_per & (per_sel == 3'(gi));
      end
   endgenerate

   // wait and ready settings by priority
   logic [2:0] rsel;
   always_comb begin
      rsel = 3'b000;
      if (hit_mid) begin
         rsel = mid_peripheral_config_reg_r[2:0]; // RULE22
      end else if (hit_lower) begin
         rsel = lower_memory_config_reg_r[2:0];
      end else if (hit_upper) begin
         rsel = upper_memory_config_reg_r[2:0];
      end else if (hit_per && per_sel >= 3'h4) begin
         rsel = mid_peripheral_config_reg_r[2:0];
      end else if (hit_per) begin
         rsel = peripheral_select_control_r[2:0];
      end
   end

   // bus cycle sequencing
   logic ignore_rdy_r;
   logic done_r;
   logic lcs_n_r, ucs_n_r;
   logic [CSW_NUM_MID-1:0] mcs_n_r;
   logic [CSW_NUM_PER-1:0] pcs_n_r;
   wire logic start_ok = cycle_start_in & ~hold_acknowledge_in & (state_r == CSW_IDLE);
   wire logic waits_left = (wcnt_r != 2'b00);
   wire logic finish = (state_r == CSW_ACTIVE) & ~waits_left
                       & (ignore_rdy_r | bus_ready_in); // RULE3 RULE27
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= CSW_IDLE;
         wcnt_r <= 2'b00;
         ignore_rdy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= finish;
         if (start_ok) begin
            state_r <= CSW_ACTIVE;
            wcnt_r <= rsel[CSW_WAIT_LSB +: CSW_WAIT_W]; // RULE18 RULE4
            ignore_rdy_r <= rsel[CSW_RDIS_BIT];
         end else if (state_r == CSW_ACTIVE && waits_left) begin
            wcnt_r <= wcnt_r - 2'b01; // RULE19
         end else if (finish) begin
            state_r <= CSW_IDLE;
         end
      end
   end

   // select outputs held low through the active cycle
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         lcs_n_r <= 1'b1;
         ucs_n_r <= 1'b1;
         mcs_n_r <= '1;
         pcs_n_r <= '1;
      end else if (hold_acknowledge_in || finish) begin
         lcs_n_r <= 1'b1; // RULE23
         ucs_n_r <= 1'b1;
         mcs_n_r <= '1;
         pcs_n_r <= {(pin_ex ? 2'b11 : pcs_n_r[6:5]), 5'h1f}; // latched bits stay
      end else if (start_ok) begin
         lcs_n_r <= ~hit_lower; // RULE26
         ucs_n_r <= ~hit_upper;
         mcs_n_r <= ~mid_vec;
         pcs_n_r <= {(pin_ex ? ~per_vec[6:5] : a[2:1]), ~per_vec[4:0]}; // selects or address
      end
   end

   // pins 5 and 6 carry latched address bits unless configured as selects
   assign peripheral_select_n_out = pcs_n_r;
   assign lower_memory_select_n_out = lcs_n_r;
   assign upper_memory_select_n_out = ucs_n_r;
   assign mid_range_select_n_out = mcs_n_r;
   assign cycle_done_out = done_r;
   assign hrdata_out = hrdata_r;
   assign hreadyout_out = hreadyout_r;
   assign hresp_out = 1'b0;
endmodule

/* test/csw_top_sva.sv */
`timescale 1ns/1ps
// port-level timing checks for the select and wait unit
module csw_top_sva (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic hsel_in,
   input wire logic [1:0] htrans_in,
   input wire logic hready_in,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic cycle_start_in,
   input wire logic hold_acknowledge_in,
   input wire logic cycle_done_out,
   input wire logic lower_memory_select_n_out,
   input wire logic upper_memory_select_n_out,
   input wire logic [3:0] mid_range_select_n_out,
   input wire logic [6:0] peripheral_select_n_out
);
   logic busy_r;
   // pins 6:5 may carry latched address bits, so they are left out
   wire logic [10:0] sel_n = {lower_memory_select_n_out, upper_memory_select_n_out,
      mid_range_select_n_out, peripheral_select_n_out[4:0]};
   wire logic taken = cycle_start_in && !hold_acknowledge_in && (!busy_r || cycle_done_out);
   // tracks an open bus cycle
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) busy_r <= 1'b0;
      else if (taken) busy_r <= 1'b1;
      else if (cycle_done_out) busy_r <= 1'b0;
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (!nrst_in);
   resp_okay_a: assert property (hresp_out == 1'b0)
      else $error("bus response not okay");
   ahb_wait_a: assert property (hsel_in && htrans_in[1] && hready_in |=>
      !hreadyout_out ##1 hreadyout_out) else $error("register answer timing wrong");
   hold_quiet_a: assert property (hold_acknowledge_in && $past(hold_acknowledge_in)
      |-> &sel_n) else $error("select active during hold");
   done_pulse_a: assert property (cycle_done_out |=> !cycle_done_out)
      else $error("done longer than one cycle");
   min_cycle_a: assert property (taken |=> !cycle_done_out)
      else $error("cycle ended too early");
   done_open_a: assert property (cycle_done_out |-> busy_r)
      else $error("done without open cycle");
   sel_release_a: assert property (|(sel_n & ~$past(sel_n)) |->
      cycle_done_out || hold_acknowledge_in) else $error("select dropped mid cycle");
   sel_start_a: assert property (|(~sel_n & $past(sel_n)) |-> $past(taken))
      else $error("select asserted without cycle");
endmodule
bind csw_top csw_top_sva csw_top_sva_inst (.clock_in, .nrst_in, .hsel_in, .htrans_in,
   .hready_in, .hreadyout_out, .hresp_out, .cycle_start_in, .hold_acknowledge_in,
   .cycle_done_out, .lower_memory_select_n_out, .upper_memory_select_n_out,
   .mid_range_select_n_out, .peripheral_select_n_out);

/* test/csw_cpu_model.sv */
`timescale 1ns/1ps
// processor bus cycle source with a slow or prompt ready return
module csw_cpu_model (
   input wire logic clock_in,
   input wire logic cycle_done_in,
   output logic cycle_start_out,
   output logic [19:0] cycle_addr_out,
   output logic cycle_mem_out,
   output logic cycle_io_out,
   output logic bus_ready_out
);
   int rdly = 0;
   int cnt = 0;
   bit act = 0;
   initial begin
      cycle_start_out = 1'b0;
      cycle_addr_out = 20'h5a5a5;
      cycle_mem_out = 1'b0;
      cycle_io_out = 1'b0;
      bus_ready_out = 1'b0;
   end
   // ready held low for rdly clocks of a cycle, toggling between cycles
   always @(posedge clock_in) begin
      if (cycle_start_out && !act) begin
         act <= 1'b1;
         cnt <= 1;
         bus_ready_out <= (rdly == 0);
      end else if (act) begin
         if (cycle_done_in) act <= 1'b0;
         bus_ready_out <= (cnt >= rdly);
         cnt <= cnt + 1;
      end else bus_ready_out <= ~bus_ready_out;
   end
   // one bus cycle, address inverted once it has completed
   task automatic run(input logic [19:0] a, input logic m, input int d, output bit ok);
      int n;
      rdly = d;
      cycle_start_out <= 1'b1;
      cycle_addr_out <= a;
      cycle_mem_out <= m;
      cycle_io_out <= !m;
      @(posedge clock_in);
      cycle_start_out <= 1'b0;
      ok = 0;
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clock_in);
         ok = cycle_done_in;
      end
      cycle_addr_out <= ~a;
      @(posedge clock_in);
   endtask
endmodule

/* test/chip_select_wait_control_test.sv */
`timescale 1ns/1ps
// self-checking bench for the chip-select and wait unit
module chip_select_wait_control_test;
   import csw_pkg::*;
   logic clock_in = 0;
   logic nrst_in = 0;
   logic hsel_in = 0;
   logic [31:0] haddr_in = 0;
   logic [1:0] htrans_in = 0;
   logic hwrite_in = 0;
   logic [2:0] hsize_in = 3'h2;
   logic [31:0] hwdata_in = 0;
   logic hold_acknowledge_in = 0;
   wire logic [31:0] hrdata_out;
   wire logic hreadyout_out, hresp_out, cycle_start_in, cycle_mem_in, cycle_io_in;
   wire logic bus_ready_in, cycle_done_out, lower_memory_select_n_out;
   wire logic upper_memory_select_n_out;
   wire logic [19:0] cycle_addr_in;
   wire logic [3:0] mid_range_select_n_out;
   wire logic [6:0] peripheral_select_n_out;
   wire logic [12:0] sel_n = {lower_memory_select_n_out, upper_memory_select_n_out,
      mid_range_select_n_out, peripheral_select_n_out};
   int mismatches = 0;
   int total_checks = 0;
   int seed = 79;
   int cnt = 0;
   bit rd_on = 0;
   bit on = 0;
   logic [12:0] gs;
   logic [31:0] rq[$];
   logic [12:0] sq[$];
   int lq[$];
   always #2 clock_in = ~clock_in;
   csw_top csw_top_inst (.clock_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
      .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out,
      .hresp_out, .cycle_start_in, .cycle_addr_in, .cycle_mem_in, .cycle_io_in,
      .bus_ready_in, .hold_acknowledge_in, .cycle_done_out, .lower_memory_select_n_out,
      .upper_memory_select_n_out, .mid_range_select_n_out, .peripheral_select_n_out);
   csw_cpu_model csw_cpu_model_inst (.clock_in, .cycle_done_in(cycle_done_out),
      .cycle_start_out(cycle_start_in), .cycle_addr_out(cycle_addr_in),
      .cycle_mem_out(cycle_mem_in), .cycle_io_out(cycle_io_in), .bus_ready_out(bus_ready_in));
   task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_cyc(input logic [12:0] es, input int el, input int gl);
      check_word("selects", 32'(es), 32'(gs));
      check_word("cycle length", el, gl);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic fail_wait;
      mismatches++;
      $display("unexpected wait: expected answer seen none");
      stop_test;
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (hreadyout_out !== 1'b1 && n < 20);
      if (hreadyout_out !== 1'b1) fail_wait;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      haddr_in <= {24'h0, a};
      hwrite_in <= w;
      wait_rdy;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      wait_rdy;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, $random(seed));
   endtask
   task automatic cyc(input logic [19:0] a, input logic m, input int d, input logic [12:0] hit,
      input int lat);
      bit ok;
      sq.push_back(~hit);
      lq.push_back(lat);
      csw_cpu_model_inst.run(a, m, d, ok);
      if (!ok) fail_wait;
   endtask
   // result watcher: register reads and completed bus cycles
   always @(posedge clock_in) begin
      if (rd_on && hreadyout_out) begin
         check_word("read data", rq.pop_front(), hrdata_out);
         rd_on = 0;
      end
      if (hsel_in && htrans_in[1] && hreadyout_out && !hwrite_in) rd_on = 1;
      if (on) cnt++;
      if (on && cnt == 1) gs = sel_n;
      if (on && cycle_done_out) begin
         check_cyc(sq.pop_front(), lq.pop_front(), cnt);
         on = 0;
      end
      if (cycle_start_in && !on && !hold_acknowledge_in) begin
         on = 1;
         cnt = 0;
      end
   end
   initial begin
      #200000;
      fail_wait;
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clock_in);
      nrst_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      rd(CSW_STATUS_OFS, 32'h0);
      rd(CSW_MIDPER_OFS, 32'h0);
      rd(CSW_PERCTL_OFS, 32'h0);
      rd(CSW_STATUS_OFS, 32'h8);
      bus(1'b1, CSW_MIDPER_OFS, 32'h1c3);
      bus(1'b1, CSW_MIDMEM_OFS, 32'h2000);
      bus(1'b1, CSW_PERCTL_OFS, 32'hffff4044);
      bus(1'b1, CSW_LOWER_OFS, 32'h5);
      bus(1'b1, CSW_UPPER_OFS, 32'he);
      bus(1'b1, 8'h18, 32'hffff);
      rd(CSW_PERCTL_OFS, 32'h4044);
      rd(CSW_MIDPER_OFS, 32'h1c3);
      rd(CSW_LOWER_OFS, 32'h5);
      rd(8'h18, 32'h0);
      rd(CSW_STATUS_OFS, 32'hf);
      cyc(20'h00000, 1'b1, 4, 13'h1000, 3);
      cyc(20'h003ff, 1'b1, 0, 13'h1000, 3);
      cyc(20'h00400, 1'b1, 2, 13'h0, 4);
      cyc(20'hff800, 1'b1, 6, 13'h0800, 4);
      cyc(20'hfffff, 1'b1, 0, 13'h0800, 4);
      cyc(20'hff7ff, 1'b1, 0, 13'h0, 2);
      for (int q = 0; q < 4; q++) begin
         cyc(20'(32'h20000 + q * 2048), 1'b1, q * 2, 13'h80 << q, (q > 1 ? q * 2 : 3) + 2);
      end
      for (int n = 0; n < 7; n++) begin
         cyc(20'(32'h40400 + n * 128), 1'b1, 3, 13'h1 << n, n < 4 ? 2 : 5);
         cyc(20'(32'h4047f + n * 128), 1'b1, 3, 13'h1 << n, n < 4 ? 2 : 5);
      end
      cyc(20'h403ff, 1'b1, 0, 13'h0, 2);
      cyc(20'h40780, 1'b1, 0, 13'h0, 2);
      cyc(20'h40400, 1'b0, 0, 13'h0, 2);
      repeat (4) cyc(20'($random(seed) & 32'h3ff), 1'b1, 0, 13'h1000, 3);
      bus(1'b1, CSW_MIDPER_OFS, 32'h183);
      bus(1'b1, CSW_PERCTL_OFS, 32'h44);
      cyc(20'h00400, 1'b0, 0, 13'h1, 2);
      cyc(20'h00400, 1'b1, 0, 13'h0, 2);
      hold_acknowledge_in <= 1'b1;
      rd(CSW_STATUS_OFS, 32'h2f);
      hold_acknowledge_in <= 1'b0;
      bus(1'b1, CSW_MIDPER_OFS, 32'h40c3);
      bus(1'b1, CSW_MIDMEM_OFS, 32'h8000);
      cyc(20'hfffff, 1'b1, 0, 13'h0c00, 5);
      // pin selector clear: pins 6:5 show latched address bits 2:1
      bus(1'b1, CSW_MIDPER_OFS, 32'h4043);
      cyc(20'hffffd, 1'b1, 0, 13'h0c20, 5);
      stop_test;
   end
endmodule
